// file: tcs_sar_adc.sv
// Package of shared constants and the 12-bit successive approximation engine
`timescale 1ns/1ps
package tcs_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SETTLE_NS     = 1000000;
  localparam int unsigned POINT_BASE    = 35716;
  localparam int          CNT_W         = 21;
  localparam int          RATE_SHIFT    = 12;
  localparam int          COORD_W       = 12;
  localparam int          REG_W         = 8;
  localparam int          AXI_AW        = 8;
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] POINT_BASE_CYC = CNT_W'(POINT_BASE);
  localparam logic [3:0] IDX_XLO  = 4'h0;
  localparam logic [3:0] IDX_XHI  = 4'h1;
  localparam logic [3:0] IDX_YLO  = 4'h2;
  localparam logic [3:0] IDX_YHI  = 4'h3;
  localparam logic [3:0] IDX_CTRL = 4'h6;
  localparam logic [3:0] IDX_RATE = 4'h7;
  localparam logic [3:0] IDX_STAT = 4'h8;
  localparam logic [3:0] IDX_IEN  = 4'h9;
  localparam logic [3:0] IDX_ICLR = 4'hA;
  localparam int CTRL_TCHG = 0;
  localparam int CTRL_CDONE = 1;
  localparam int CTRL_PERIODIC = 2;
  localparam int EV_TCHG = 0;
  localparam int EV_CDONE = 1;
  localparam logic [REG_W-1:0] RATE_RST = 8'h20;
  localparam logic [1:0] IEN_RST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SAR_WAIT = 2'h3;
  localparam logic [3:0] SAR_TOP = 4'hB;
  typedef struct packed {
    logic [3:0] lvl;
    logic [3:0] drv;
    logic       sense_y;
  } tcs_plates_t;
  typedef struct packed {
    logic [COORD_W-1:0] x;
    logic [COORD_W-1:0] y;
  } tcs_point_t;
  // Plate order in lvl and drv: x_plate_high, x_plate_low, y_plate_high,
  // y_plate_low
  localparam tcs_plates_t PL_OFF  = '{4'h0, 4'h0, 1'b0};
  localparam tcs_plates_t PL_WAIT = '{4'h3, 4'h3, 1'b0};
  localparam tcs_plates_t PL_X    = '{4'h8, 4'hC, 1'b1};
  localparam tcs_plates_t PL_Y    = '{4'h2, 4'h3, 1'b0};
endpackage

module tcs_sar_adc (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  input  wire logic                        start,
  input  wire logic                        cmp,
  output logic [tcs_pkg::COORD_W-1:0]      dac_q,
  output logic [tcs_pkg::COORD_W-1:0]      code_q,
  output logic                             done_q
);
  import tcs_pkg::*;
  logic               busy_q, busy_d, done_d;
  logic [3:0]         bit_q, bit_d;
  logic [1:0]         wait_q, wait_d;
  logic [COORD_W-1:0] acc, dac_d, code_d;

  // Binary search keeps codes monotonic with every value reachable
  always_comb begin
    busy_d = busy_q;
    bit_d  = bit_q;
    wait_d = wait_q;
    dac_d  = dac_q;
    code_d = code_q;
    done_d = 1'b0;
    acc    = cmp ? dac_q : (dac_q & ~(COORD_W'(1) << bit_q));
    if (start) begin
      busy_d = 1'b1;
      bit_d  = SAR_TOP;
      wait_d = SAR_WAIT;
      dac_d  = COORD_W'(1) << SAR_TOP;
    end else if (busy_q) begin
      if (wait_q != 2'h0) begin
        wait_d = wait_q - 2'h1;
      end else if (bit_q == 4'h0) begin
        busy_d = 1'b0;
        code_d = acc;
        done_d = 1'b1;
      end else begin
        bit_d  = bit_q - 4'h1;
        wait_d = SAR_WAIT;
        dac_d  = acc | (COORD_W'(1) << (bit_q - 4'h1));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      bit_q  <= 4'h0;
      wait_q <= 2'h0;
      dac_q  <= '0;
      code_q <= '0;
      done_q <= 1'b0;
    end else if (ce) begin
      busy_q <= busy_d;
      bit_q  <= bit_d;
      wait_q <= wait_d;
      dac_q  <= dac_d;
      code_q <= code_d;
      done_q <= done_d;
    end
  end
endmodule // tcs_sar_adc

// file: tcs_screen_model.sv
// Touch screen model seen by the sequencer's plate drivers and comparator
`timescale 1ns/1ps
module tcs_screen_model (
  input  wire tcs_pkg::tcs_plates_t        plates,
  input  wire logic [tcs_pkg::COORD_W-1:0] dac_code,
  input  wire logic                        touched,
  input  wire logic [tcs_pkg::COORD_W-1:0] x_pos,
  input  wire logic [tcs_pkg::COORD_W-1:0] y_pos,
  output logic                             touch_in,
  output logic                             adc_cmp
);
  import tcs_pkg::*;
  logic [COORD_W-1:0] sensed;
  // Sense plate sits at the touch point's fraction of full scale
  assign sensed = plates.sense_y ? x_pos : y_pos;
  // A lifted pen leaves the sense plate floating, so its level is junk
  assign adc_cmp = touched ? (sensed >= dac_code) : ~dac_code[0];
  assign touch_in = touched;
endmodule // tcs_screen_model

// file: tcs_top.sv
// Touch conversion sequencer with AXI4-Lite register port
// Contract
// - A conversion cycle starts no sooner than 1 ms after the touch alert.
// - With the clock stopped a touch still sets contact low and irq high.
// - Results stay invalid after a clock restart until a second full cycle ends.
// - X and Y are converted to 12 bits at a rate set by control and rate.
// - Codes are ratiometric with full screen voltage at code 4095.
// - Codes rise monotonically and every code can be reached.
// - Any register read clears the interrupt unless one is being set.
// - A point takes 35716 plus 4096 times the rate count clock cycles.
// - Reset clears X, control and loads the rate count with 32.
// - Writing zero to control clears any pending interrupt.
`timescale 1ns/1ps
module tcs_top #(
  parameter logic [tcs_pkg::CNT_W-1:0] SETTLE_CYC = tcs_pkg::SETTLE_CYC,
  parameter logic [tcs_pkg::CNT_W-1:0] POINT_BASE = tcs_pkg::POINT_BASE_CYC
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic                        ce,
  input  wire logic [tcs_pkg::AXI_AW-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic [tcs_pkg::AXI_AW-1:0]  araddr,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  input  wire logic                        touch_in,
  input  wire logic                        adc_cmp,
  output tcs_pkg::tcs_plates_t             plates,
  output logic [tcs_pkg::COORD_W-1:0]      dac_code,
  output logic                             touch_n,
  output logic                             irq
);
  import tcs_pkg::*;
  typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_CONV_X, S_CONV_Y, S_PERIOD}
    tcs_state_t;

  tcs_state_t         st_q, st_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d, period_len;
  tcs_point_t         pt_q, pt_d;
  logic [COORD_W-1:0] xs_q, xs_d, sar_code;
  tcs_plates_t        pl_q, pl_d;
  logic fresh_q, fresh_d, valid_q, valid_d, ce_q;
  logic sar_start, sar_done, cdone_evt, rel_evt, run;
  logic touch_m_q, touch_s_q, touch_p_q, cmp_m_q, cmp_s_q;
  logic [1:0] stat_q, stat_d, ien_q, ien_d, evt;
  logic irq_q, press_evt, rd_clr, zero_wr, clr_wr;
  logic [REG_W-1:0] ctrl_q, ctrl_d, rate_q, rate_d, rd_val;
  logic [AXI_AW-1:0] aw_q, aw_d;
  logic [REG_W-1:0] wd_q, wd_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d, ws_q, ws_d;
  logic awready_q, wready_q, bvalid_q, bvalid_d, arready_q, arready_d;
  logic rvalid_q, rvalid_d, do_wr, rd_ok;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [3:0] widx, ridx;

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign plates  = pl_q;
  assign irq     = irq_q;

  tcs_sar_adc u_sar (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (sar_start),
    .cmp     (cmp_s_q),
    .dac_q   (dac_code),
    .code_q  (sar_code),
    .done_q  (sar_done)
  );

  // Sequencer
  assign run = (ctrl_q != '0) && ctrl_q[CTRL_PERIODIC];
  assign period_len = POINT_BASE + (CNT_W'(rate_q) << RATE_SHIFT);
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + CNT_W'(1);
    pt_d = pt_q;
    xs_d = xs_q;
    pl_d = pl_q;
    fresh_d = fresh_q;
    valid_d = valid_q;
    sar_start = 1'b0;
    cdone_evt = 1'b0;
    rel_evt = 1'b0;
    if (ce && !ce_q) begin
      fresh_d = 1'b0;
      valid_d = 1'b0;
    end
    unique case (st_q)
      S_IDLE: begin
        cnt_d = '0;
        pl_d = (ctrl_q != '0) ? PL_WAIT : PL_OFF;
        if (run && touch_s_q) st_d = S_SETTLE;
      end
      S_SETTLE: begin
        if (cnt_q >= SETTLE_CYC - CNT_W'(1)) begin
          st_d = S_CONV_X;
          cnt_d = '0;
          sar_start = 1'b1;
          pl_d = PL_X;
        end
      end
      S_CONV_X: begin
        if (sar_done) begin
          xs_d = sar_code;
          st_d = S_CONV_Y;
          sar_start = 1'b1;
          pl_d = PL_Y;
        end
      end
      S_CONV_Y: begin
        if (sar_done) begin
          pt_d = '{xs_q, sar_code};
          cdone_evt = 1'b1;
          valid_d = fresh_q;
          fresh_d = 1'b1;
          st_d = S_PERIOD;
          pl_d = PL_WAIT;
        end
      end
      S_PERIOD: begin
        if (cnt_q >= period_len - CNT_W'(1)) begin
          cnt_d = '0;
          if (touch_s_q) begin
            st_d = S_CONV_X;
            sar_start = 1'b1;
            pl_d = PL_X;
          end else begin
            st_d = S_IDLE;
            rel_evt = 1'b1;
          end
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (!run) begin
      st_d = S_IDLE;
      sar_start = 1'b0;
      pl_d = (ctrl_q != '0) ? PL_WAIT : PL_OFF;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      cnt_q <= '0;
      pt_q <= '0;
      xs_q <= '0;
      pl_q <= PL_OFF;
      fresh_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pt_q <= pt_d;
      xs_q <= xs_d;
      pl_q <= pl_d;
      fresh_q <= fresh_d;
      valid_q <= valid_d;
    end
  end

  // Touch detection and interrupt run even with the clock enable low
  assign press_evt = touch_s_q && !touch_p_q && st_q == S_IDLE;
  assign evt[EV_TCHG] = ctrl_q[CTRL_TCHG] && (press_evt || (ce && rel_evt));
  assign evt[EV_CDONE] = ctrl_q[CTRL_CDONE] && ce && cdone_evt;
  always_comb begin
    stat_d = stat_q;
    if (rd_clr || zero_wr) stat_d = '0;
    if (clr_wr) stat_d = stat_d & ~wd_q[1:0];
    stat_d = stat_d | evt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      touch_m_q <= 1'b0;
      touch_s_q <= 1'b0;
      touch_p_q <= 1'b0;
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
      ce_q <= 1'b1;
      stat_q <= '0;
      irq_q <= 1'b0;
      touch_n <= 1'b1;
    end else begin
      touch_m_q <= touch_in;
      touch_s_q <= touch_m_q;
      touch_p_q <= touch_s_q;
      cmp_m_q <= adc_cmp;
      cmp_s_q <= cmp_m_q;
      ce_q <= ce;
      stat_q <= stat_d;
      irq_q <= |(stat_d & ien_q);
      touch_n <= !touch_s_q;
    end
  end

  // AXI4-Lite slave, one write and one read in flight
  assign widx = aw_q[5:2];
  assign ridx = araddr[5:2];
  assign rd_ok = araddr[7:6] == 2'h0 && ridx <= IDX_ICLR;
  assign do_wr = ce && aw_have_q && w_have_q && !bvalid_q;
  assign rd_clr = ce && arvalid && arready_q;
  assign zero_wr = do_wr && ws_q && widx == IDX_CTRL && wd_q == '0;
  assign clr_wr = do_wr && ws_q && widx == IDX_ICLR;
  always_comb begin
    unique case (ridx)
      IDX_XLO: rd_val = pt_q.x[7:0];
      IDX_XHI: rd_val = {4'h0, pt_q.x[11:8]};
      IDX_YLO: rd_val = pt_q.y[7:0];
      IDX_YHI: rd_val = {4'h0, pt_q.y[11:8]};
      IDX_CTRL: rd_val = ctrl_q;
      IDX_RATE: rd_val = rate_q;
      IDX_STAT: rd_val = {1'b0, st_q != S_IDLE, valid_q, touch_s_q, 2'h0,
                          stat_q};
      IDX_IEN: rd_val = {6'h00, ien_q};
      default: rd_val = '0;
    endcase
  end
  always_comb begin
    aw_d = aw_q;
    wd_d = wd_q;
    ws_d = ws_q;
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    rate_d = rate_q;
    ien_d = ien_q;
    if (awvalid && awready_q) begin
      aw_d = awaddr;
      aw_have_d = 1'b1;
    end
    if (wvalid && wready_q) begin
      wd_d = wdata[REG_W-1:0];
      ws_d = wstrb[0];
      w_have_d = 1'b1;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (aw_q[7:6] == 2'h0 && widx <= IDX_ICLR) ? RESP_OKAY
                                                          : RESP_SLVERR;
      if (ws_q && aw_q[7:6] == 2'h0) begin
        if (widx == IDX_CTRL) ctrl_d = wd_q;
        if (widx == IDX_RATE) rate_d = wd_q;
        if (widx == IDX_IEN) ien_d = wd_q[1:0];
      end
    end
    rvalid_d = rvalid_q && !rready;
    arready_d = arready_q || (rvalid_q && rready);
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arvalid && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rdata_d = {24'h000000, rd_ok ? rd_val : 8'h00};
      rresp_d = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= '0;
      wd_q <= '0;
      ws_q <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      ctrl_q <= '0;
      rate_q <= RATE_RST;
      ien_q <= IEN_RST;
    end else if (ce) begin
      aw_q <= aw_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awready_q <= !aw_have_d;
      wready_q <= !w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      rate_q <= rate_d;
      ien_q <= ien_d;
    end
  end

  chk_settle_min: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && st_q == S_SETTLE && st_d == S_CONV_X) |-> cnt_q >= SETTLE_CYC - 1)
    else $error("conversion began before settle time");
  chk_touch_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    (touch_s_q && !ce) |=> !touch_n)
    else $error("contact output not low on touch");
  chk_restart_inv: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !ce_q) |=> !valid_q)
    else $error("valid flag survived clock restart");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_clr && evt == '0 && !clr_wr) |=> stat_q == '0 && !irq_q)
    else $error("read did not clear interrupt");
  chk_period_len: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && st_q == S_PERIOD && st_d != S_PERIOD && run) |->
      cnt_q == period_len - 1)
    else $error("point period wrong");
  chk_reset_vals: assert property (@(posedge aclk)
    $rose(aresetn) |-> ctrl_q == '0 && rate_q == RATE_RST && pt_q.x == '0)
    else $error("reset values wrong");
  chk_zero_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
    (zero_wr && evt == '0) |=> stat_q == '0)
    else $error("zero control write kept interrupt");
  chk_xy_order: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && cdone_evt) |-> st_q == S_CONV_Y ##1 pt_q.y == $past(sar_code))
    else $error("completion before both coordinates stored");
  chk_release_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rel_evt && run && ctrl_q[CTRL_TCHG]) |=> st_q == S_IDLE &&
      stat_q[EV_TCHG])
    else $error("release not flagged");
endmodule // tcs_top

// file: tcs_top_tb_top.sv
// Self-checking testbench of the touch conversion sequencer
`timescale 1ns/1ps
module tcs_top_tb_top;
  import tcs_pkg::*;
  // Short settle and base counts keep the run brief
  localparam int SETN = 20;
  localparam int PERIOD = 200 + 4096;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        touch_in, adc_cmp, touch_n, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  tcs_plates_t plates;
  logic [11:0] dac_code;
  logic        touched = 1'b0;
  logic [11:0] x_pos = 12'h000;
  logic [11:0] y_pos = 12'h000;
  logic [11:0] xs[3], ys[3];
  logic [33:0] rq[$], bq[$], re, be;
  int          mismatches = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          t0, tp;

  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  tcs_top #(.SETTLE_CYC(CNT_W'(SETN)), .POINT_BASE(CNT_W'('hC8))) i_tcs_top (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .touch_in(touch_in), .adc_cmp(adc_cmp),
    .plates(plates), .dac_code(dac_code), .touch_n(touch_n), .irq(irq));

  tcs_screen_model i_tcs_screen_model (
    .plates(plates), .dac_code(dac_code), .touched(touched),
    .x_pos(x_pos), .y_pos(y_pos), .touch_in(touch_in), .adc_cmp(adc_cmp));

  task automatic final_report();
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tmo();
    mismatches++;
    final_report();
  endtask

  function automatic logic [7:0] a(input logic [3:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  function automatic logic [33:0] ok(input logic [7:0] d);
    return {RESP_OKAY, 24'h0, d};
  endfunction

  // Read results are judged by the monitor below, in issue order
  task automatic rd(input logic [3:0] idx, input logic [33:0] e);
    int k;
    k = 0;
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      k++;
    end while (rvalid !== 1'b1 && k < 200);
    rready <= 1'b0;
    if (k >= 200) tmo();
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    int k;
    k = 0;
    bq.push_back({er, 32'h0});
    @(posedge aclk);
    awaddr <= a(idx);
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      k++;
    end while (bvalid !== 1'b1 && k < 200);
    bready <= 1'b0;
    if (k >= 200) tmo();
  endtask

  task automatic wait_pl(input tcs_plates_t p);
    int k;
    k = 0;
    while (plates !== p && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 20000) tmo();
  endtask

  task automatic wait_irq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 20000) tmo();
  endtask

  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready && rq.size() > 0) begin
      re = rq.pop_front();
      chk("rdata", rdata, re[31:0]);
      chk("rresp", {30'h0, rresp}, {30'h0, re[33:32]});
    end
    if (bvalid === 1'b1 && bready && bq.size() > 0) begin
      be = bq.pop_front();
      chk("bresp", {30'h0, bresp}, {30'h0, be[33:32]});
    end
  end

  initial begin
    void'($urandom(32'h281F6681));
    xs = '{12'h000, 12'hFFF, 12'($urandom_range(4095))};
    ys = '{12'hFFF, 12'h000, 12'($urandom_range(4095))};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_CTRL, ok(8'h00));
    rd(IDX_RATE, ok(8'h20));
    rd(IDX_XLO, ok(8'h00));
    rd(IDX_XHI, ok(8'h00));
    rd(IDX_IEN, ok(8'h03));
    rd(4'hB, {RESP_SLVERR, 32'h0});
    wr(4'hB, 8'h5A, RESP_SLVERR);
    wr(IDX_XLO, 8'hFF, RESP_OKAY);
    rd(IDX_XLO, ok(8'h00));
    wr(IDX_RATE, 8'h01, RESP_OKAY);
    wr(IDX_CTRL, 8'h07, RESP_OKAY);
    // Boundary codes first, then a random point
    for (int i = 0; i < 3; i++) begin
      x_pos <= xs[i];
      y_pos <= ys[i];
      if (i == 0) begin
        touched <= 1'b1;
        wait_irq();
        t0 = cyc;
        rd(IDX_CTRL, ok(8'h07));
        repeat (2) @(posedge aclk);
        chk("irq_clr", {31'h0, irq}, 32'h0);
      end
      wait_pl(PL_X);
      if (i == 0) chk("settle", {31'h0, cyc - t0 >= SETN}, 32'h1);
      else chk("period", 32'(cyc - tp), 32'(PERIOD));
      tp = cyc;
      wait_pl(PL_Y);
      wait_irq();
      // Host keeps the point only while touch is still reported
      rd(IDX_STAT, ok(i == 0 ? 8'h52 : 8'h72));
      rd(IDX_XLO, ok(xs[i][7:0]));
      rd(IDX_XHI, ok({4'h0, xs[i][11:8]}));
      rd(IDX_YLO, ok(ys[i][7:0]));
      rd(IDX_YHI, ok({4'h0, ys[i][11:8]}));
    end
    touched <= 1'b0;
    wait_irq();
    rd(IDX_STAT, ok(8'h21));
    // Stopped clock: contact and alert still work, nothing else moves
    ce <= 1'b0;
    touched <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("touch_n", {31'h0, touch_n}, 32'h0);
    chk("irq_stop", {31'h0, irq}, 32'h1);
    repeat (100) @(posedge aclk);
    chk("plates", {23'h0, plates}, {23'h0, PL_WAIT});
    ce <= 1'b1;
    rd(IDX_CTRL, ok(8'h07));
    wait_irq();
    rd(IDX_STAT, ok(8'h52));
    wait_irq();
    rd(IDX_STAT, ok(8'h72));
    touched <= 1'b0;
    wait_irq();
    rd(IDX_STAT, ok(8'h21));
    // Masked event, explicit clear, then power-down write
    wr(IDX_IEN, 8'h00, RESP_OKAY);
    touched <= 1'b1;
    repeat (10) @(posedge aclk);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    wr(IDX_ICLR, 8'h01, RESP_OKAY);
    rd(IDX_STAT, ok(8'h70));
    rd(IDX_IEN, ok(8'h00));
    wr(IDX_IEN, 8'h03, RESP_OKAY);
    wait_irq();
    wr(IDX_CTRL, 8'h00, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq_pd", {31'h0, irq}, 32'h0);
    final_report();
  end
endmodule // tcs_top_tb_top
